//--- src/wdog_lamp_reset_supervisor.sv
// watchdog, warning-lamp drivers and reset-pin supervisor with its status registers
// assumes a byte register port decoded upstream and open-drain pads resolved outside

module wdog_lamp_reset_supervisor import wdog_lamp_pkg::*; #(
  parameter int REARM_CYC = WD_REARM_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       watchdogPulseIn,
  input  wire logic       lampGateInputOne,
  input  wire logic       lampGateInputTwo,
  input  wire faultPins_s faultPins,
  input  wire logic       resetPinIn,
  output logic            resetPinOut,
  output logic            resetPinOe,
  output logic            lowVoltageLampOut,
  output logic            lowVoltageLampOe,
  output logic            hvLampDriverOne,
  output logic            hvLampDriverTwo,
  output logic            driversInhibit,
  input  wire regReq_s    regReq,
  output logic [7:0]      regRdData
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [9:0] syncA_q, syncB_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      syncA_q <= 10'h001;
      syncB_q <= 10'h001;
    end else begin
      syncA_q <= {watchdogPulseIn, lampGateInputOne, lampGateInputTwo, faultPins, resetPinIn};
      syncB_q <= syncA_q;
    end
  end

  logic       wdPin, gateOne, gateTwo, pinLevel;
  faultPins_s flt;
  assign wdPin    = syncB_q[9];
  assign gateOne  = syncB_q[8];
  assign gateTwo  = syncB_q[7];
  assign flt      = syncB_q[6:1];
  assign pinLevel = syncB_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // deglitched live lamp faults
  logic [1:0] ocLive;
  logic       otLive;

  fault_deglitch #(.N(OC_DEGLITCH_CYC)) u_oc1 (
    .mclk     (mclk),
    .rstn     (rstn),
    .faultIn  (flt.overCur[0]),
    .faultOut (ocLive[0])
  );
  fault_deglitch #(.N(OC_DEGLITCH_CYC)) u_oc2 (
    .mclk     (mclk),
    .rstn     (rstn),
    .faultIn  (flt.overCur[1]),
    .faultOut (ocLive[1])
  );
  fault_deglitch #(.N(OT_DEGLITCH_CYC)) u_ot (
    .mclk     (mclk),
    .rstn     (rstn),
    .faultIn  (flt.overTemp),
    .faultOut (otLive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] ctrl_q, wcfg_q;
  logic       wrCtrl, wrCfg, rdGlobal, rdLamp;
  assign wrCtrl   = regReq.wr && regReq.addr == ADDR_CTRL;
  assign wrCfg    = regReq.wr && regReq.addr == ADDR_WCFG;
  assign rdGlobal = regReq.rd && regReq.addr == ADDR_GLOBAL;
  assign rdLamp   = regReq.rd && regReq.addr == ADDR_LAMP;

  always_ff @(posedge mclk) begin
    if (!rstn) ctrl_q <= CTRL_RST;
    else if (wrCtrl) ctrl_q <= regReq.wdata & CTL_RW_MASK;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) wcfg_q <= WCFG_RST;
    else if (wrCfg) wcfg_q <= regReq.wdata;
  end

  logic wdEnable;
  assign wdEnable = ctrl_q[CTL_WDEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sequencing
  wdState_e   state_q;
  logic [31:0] timer_q;
  logic [2:0] cnt_q;
  logic       wdFault_q, wdStatus_q;
  logic       good, bad, tmo;
  logic       run;
  logic       dropToZero;

  assign run = (state_q == WD_RUN);

  wd_pulse_meter u_meter (
    .mclk      (mclk),
    .rstn      (rstn),
    .run       (run),
    .pulseIn   (wdPin),
    .lowSel    (wcfg_q[CFG_LO_LSB +: 2]),
    .highSel   (wcfg_q[CFG_HI_LSB +: 2]),
    .goodPulse (good),
    .badPulse  (bad),
    .timeout   (tmo)
  );

  // a timeout is treated as an immediate fall to zero
  assign dropToZero = run && cnt_q != 3'h0 && (tmo || (bad && cnt_q <= CNT_BAD_STEP));

  always_ff @(posedge mclk) begin
    if (!rstn || !run) begin
      cnt_q <= 3'h0;
    end else if (tmo) begin
      cnt_q <= 3'h0;
    end else if (bad) begin
      if (cnt_q <= CNT_BAD_STEP) cnt_q <= 3'h0;
      else cnt_q <= cnt_q - CNT_BAD_STEP;
    end else if (good && cnt_q != CNT_FULL) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= WD_OFF;
      timer_q <= 32'h0;
    end else begin
      unique case (state_q)
        WD_OFF: begin
          if (wdEnable) state_q <= WD_RUN;
        end
        WD_RUN: begin
          if (!wdEnable) begin
            state_q <= WD_OFF;
          end else if (dropToZero) begin
            state_q <= WD_PULSE;
            timer_q <= 32'h0;
          end
        end
        WD_PULSE: begin
          if (timer_q == 32'(RST_PULSE_CYC - 1)) begin
            state_q <= WD_REARM;
            timer_q <= 32'h0;
          end else begin
            timer_q <= timer_q + 32'h1;
          end
        end
        WD_REARM: begin
          // gives the controller time to come out of its own reset
          if (!wdEnable) state_q <= WD_OFF;
          else if (timer_q == 32'(REARM_CYC - 1)) state_q <= WD_RUN;
          else timer_q <= timer_q + 32'h1;
        end
      endcase
    end
  end

  // fault holds from count zero until the count is full again
  always_ff @(posedge mclk) begin
    if (!rstn || !wdEnable) begin
      wdFault_q  <= 1'b0;
      wdStatus_q <= 1'b0;
    end else if (cnt_q == 3'h0 || state_q != WD_RUN) begin
      wdFault_q  <= 1'b1;
      wdStatus_q <= 1'b0;
    end else if (cnt_q == CNT_FULL) begin
      wdFault_q  <= 1'b0;
      wdStatus_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin: power-on hold, watchdog pulse, external reset detection
  logic                    porHold_q;
  logic [15:0]             porCnt_q;
  logic [EXT_MASK_CYC-1:0] oeHist_q;
  logic                    extLow_q, erst_q;
  logic                    pinDriven;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      porHold_q <= 1'b1;
      porCnt_q  <= 16'h0000;
    end else if (porHold_q) begin
      if (porCnt_q == 16'(RST_PULSE_CYC - 1)) porHold_q <= 1'b0;
      else porCnt_q <= porCnt_q + 16'h0001;
    end
  end

  assign pinDriven = porHold_q || state_q == WD_PULSE;

  // own drive is masked until it has cleared the synchroniser
  always_ff @(posedge mclk) begin
    if (!rstn) oeHist_q <= '1;
    else oeHist_q <= {oeHist_q[EXT_MASK_CYC-2:0], pinDriven};
  end

  always_ff @(posedge mclk) begin
    if (!rstn) extLow_q <= 1'b0;
    else if (!pinLevel && !pinDriven && oeHist_q == '0) extLow_q <= 1'b1;
    else if (pinLevel) extLow_q <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) erst_q <= 1'b0;
    else if (extLow_q && pinLevel) erst_q <= 1'b1;
    else if (rdGlobal) erst_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lamp drivers and fault flags
  logic wdKill, lampOne, lampTwo;
  logic [7:0] lampFlags_q;
  logic fail_q;
  logic [7:0] lampSet;

  assign wdKill  = wdEnable && wdFault_q;
  // live faults only; latched flags never gate a driver
  assign lampOne = gateOne && ctrl_q[CTL_EN1_BIT] && !otLive && !flt.underVolt
                   && !wdKill;
  assign lampTwo = gateTwo && ctrl_q[CTL_EN2_BIT] && !otLive && !flt.underVolt
                   && !wdKill;

  always_comb begin
    lampSet               = 8'h00;
    lampSet[LMP_OC1_BIT]  = ocLive[0];
    lampSet[LMP_OC2_BIT]  = ocLive[1];
    lampSet[LMP_OL1_BIT]  = flt.openLoad[0] && !hvLampDriverOne;
    lampSet[LMP_OL2_BIT]  = flt.openLoad[1] && !hvLampDriverTwo;
    lampSet[LMP_OVERTEMP_SHUTDOWN_FLAG_BIT] = otLive;
  end

  // a set in the clearing cycle wins, so a standing fault stays visible
  always_ff @(posedge mclk) begin
    if (!rstn) lampFlags_q <= 8'h00;
    else if (rdLamp) lampFlags_q <= lampSet;
    else lampFlags_q <= lampFlags_q | lampSet;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fail_q <= 1'b0;
    end else if (ocLive != 2'b00 || lampSet[LMP_OL1_BIT] || lampSet[LMP_OL2_BIT]) begin
      fail_q <= 1'b1;
    end else if (rdGlobal) begin
      fail_q <= 1'b0;
    end
  end

  logic hv1_q, hv2_q, inhibit_q, lvLamp_q, rstOe_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hv1_q     <= 1'b0;
      hv2_q     <= 1'b0;
      inhibit_q <= 1'b0;
      lvLamp_q  <= 1'b0;
      rstOe_q   <= 1'b1;
    end else begin
      hv1_q     <= lampOne;
      hv2_q     <= lampTwo;
      inhibit_q <= wdKill;
      lvLamp_q  <= wdKill;
      rstOe_q   <= pinDriven;
    end
  end

  assign hvLampDriverOne   = hv1_q;
  assign hvLampDriverTwo   = hv2_q;
  assign driversInhibit    = inhibit_q;
  assign lowVoltageLampOut = 1'b0;
  assign lowVoltageLampOe  = lvLamp_q;
  assign resetPinOut       = 1'b0;
  assign resetPinOe        = rstOe_q;

  ////////////////////////////////////////////////////////////////////////////
  // read port: data registered on the edge that takes the strobe
  logic [7:0] rdData_q, rdMux;
  always_comb begin
    rdMux = 8'h00;
    unique case (regReq.addr)
      ADDR_GLOBAL: begin
        rdMux[GLB_FAIL_BIT] = fail_q;
        rdMux[GLB_ERST_BIT] = erst_q;
        rdMux[GLB_FUV_BIT]  = flt.underVolt;
      end
      ADDR_LAMP:  rdMux = lampFlags_q;
      ADDR_WDCNT: rdMux = {4'h0, wdStatus_q, cnt_q};
      ADDR_CTRL: begin
        rdMux              = ctrl_q;
        rdMux[CTL_WDF_BIT] = wdFault_q;
      end
      ADDR_WCFG:  rdMux = wcfg_q;
      default:    rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) rdData_q <= 8'h00;
    else if (regReq.rd) rdData_q <= rdMux;
  end

  assign regRdData = rdData_q;

endmodule

//--- src/wdog_lamp_pkg.sv
// constants, register map and carrier types for the watchdog / lamp supervisor
// assumes a single 25 MHz clock domain and a plain byte-wide register port
package wdog_lamp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int MCLK_PERIOD_NS   = 40;
  localparam int OC_DEGLITCH_NS   = 10000;
  localparam int OC_DEGLITCH_CYC  = (OC_DEGLITCH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int OT_DEGLITCH_NS   = 50000;
  localparam int OT_DEGLITCH_CYC  = (OT_DEGLITCH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int RST_PULSE_NS     = 20000;
  localparam int RST_PULSE_CYC    = (RST_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int WD_REARM_NS      = 1000000;
  localparam int WD_REARM_CYC     = (WD_REARM_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int WD_TICK_NS       = 1000;
  localparam int WD_TICK_CYC      = WD_TICK_NS / MCLK_PERIOD_NS;
  localparam int EXT_MASK_CYC     = 3;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] ADDR_GLOBAL = 6'h00;
  localparam logic [5:0] ADDR_LAMP   = 6'h03;
  localparam logic [5:0] ADDR_WDCNT  = 6'h05;
  localparam logic [5:0] ADDR_CTRL   = 6'h11;
  localparam logic [5:0] ADDR_WCFG   = 6'h12;

  localparam int GLB_FAIL_BIT   = 0;
  localparam int GLB_ERST_BIT   = 3;
  localparam int GLB_FUV_BIT    = 4;
  localparam int LMP_OC1_BIT    = 0;
  localparam int LMP_OL1_BIT    = 1;
  localparam int LMP_OC2_BIT    = 2;
  localparam int LMP_OL2_BIT    = 3;
  localparam int LMP_OVERTEMP_SHUTDOWN_FLAG_BIT   = 6;
  localparam int WDC_STAT_BIT   = 3;
  localparam int CTL_EN1_BIT    = 0;
  localparam int CTL_EN2_BIT    = 1;
  localparam int CTL_WDEN_BIT   = 4;
  localparam int CTL_WDF_BIT    = 7;
  localparam logic [7:0] CTL_RW_MASK = 8'h3F;
  localparam int CFG_HI_LSB     = 6;
  localparam int CFG_LO_LSB     = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WCFG_RST = 8'h00;

  localparam logic [2:0] CNT_FULL = 3'h7;
  localparam logic [2:0] CNT_BAD_STEP = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    WD_OFF   = 2'b00,
    WD_RUN   = 2'b01,
    WD_PULSE = 2'b10,
    WD_REARM = 2'b11
  } wdState_e;

  typedef struct packed {
    logic       underVolt;
    logic       overTemp;
    logic [1:0] overCur;
    logic [1:0] openLoad;
  } faultPins_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } regReq_s;

  // window limits in watchdog ticks
  function automatic logic [15:0] lowerTicks(input logic [1:0] sel);
    case (sel)
      2'b00:   lowerTicks = 16'h0064;
      2'b01:   lowerTicks = 16'h00C8;
      2'b10:   lowerTicks = 16'h0190;
      default: lowerTicks = 16'h0320;
    endcase
  endfunction

  function automatic logic [15:0] upperTicks(input logic [1:0] sel);
    case (sel)
      2'b00:   upperTicks = 16'h03E8;
      2'b01:   upperTicks = 16'h07D0;
      2'b10:   upperTicks = 16'h0FA0;
      default: upperTicks = 16'h1F40;
    endcase
  endfunction

endpackage

//--- src/fault_deglitch.sv
// qualifies a synchronised fault level: high only after it stayed high N cycles
// assumes the input has already passed a two-flop synchroniser
module fault_deglitch import wdog_lamp_pkg::*; #(
  parameter int N = 1
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic faultIn,
  output logic      faultOut
);

  logic [15:0] cnt_q;
  logic        out_q;

  // a fault that drops releases at once; only the assertion is filtered
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else if (!faultIn) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else if (cnt_q >= 16'(N - 1)) begin
      out_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign faultOut = out_q;

endmodule

//--- src/wd_pulse_meter.sv
// measures pulse high time in watchdog ticks and classifies it against the window
// assumes pulseIn is synchronised; events are one-cycle pulses on mclk
module wd_pulse_meter import wdog_lamp_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       pulseIn,
  input  wire logic [1:0] lowSel,
  input  wire logic [1:0] highSel,
  output logic            goodPulse,
  output logic            badPulse,
  output logic            timeout
);

  logic [7:0]  pre_q;
  logic        tick;
  logic        prev_q;
  logic        inPulse_q;
  logic [15:0] width_q;
  logic [16:0] idle_q;
  logic        timedOut_q;
  logic        good_q, bad_q, to_q;
  logic        rise, fall;

  assign tick = (pre_q == 8'(WD_TICK_CYC - 1));
  assign rise = pulseIn & ~prev_q;
  assign fall = ~pulseIn & prev_q;

  always_ff @(posedge mclk) begin
    if (!rstn || !run || tick) pre_q <= 8'h00;
    else pre_q <= pre_q + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) prev_q <= 1'b0;
    else prev_q <= pulseIn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // width counter saturates so a stuck-high pin still reads as too long
  always_ff @(posedge mclk) begin
    if (!rstn || !run) begin
      inPulse_q <= 1'b0;
      width_q   <= 16'h0000;
      good_q    <= 1'b0;
      bad_q     <= 1'b0;
    end else begin
      good_q <= 1'b0;
      bad_q  <= 1'b0;
      if (rise) begin
        inPulse_q <= 1'b1;
        width_q   <= 16'h0000;
      end else if (fall && inPulse_q) begin
        inPulse_q <= 1'b0;
        if (width_q >= lowerTicks(lowSel) && width_q <= upperTicks(highSel))
          good_q <= 1'b1;
        else
          bad_q <= 1'b1;
      end else if (inPulse_q && tick && width_q != 16'hFFFF) begin
        width_q <= width_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rstn || !run || rise || fall) begin
      idle_q     <= 17'h00000;
      timedOut_q <= 1'b0;
      to_q       <= 1'b0;
    end else begin
      to_q <= 1'b0;
      if (!timedOut_q && idle_q >= {upperTicks(highSel), 1'b0}) begin
        timedOut_q <= 1'b1;
        to_q       <= 1'b1;
      end else if (tick && !timedOut_q) begin
        idle_q <= idle_q + 17'h00001;
      end
    end
  end

  assign goodPulse = good_q;
  assign badPulse  = bad_q;
  assign timeout   = to_q;

endmodule

//--- verif/wdog_lamp_props.sv
// concurrent checks on the supervisor's top-level ports
// assumes one mclk domain; enable bits are tracked from observed register writes
module wdog_lamp_props import wdog_lamp_pkg::*; (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       watchdogPulseIn,
  input wire logic       lampGateInputOne,
  input wire logic       lampGateInputTwo,
  input wire faultPins_s faultPins,
  input wire logic       resetPinIn,
  input wire logic       resetPinOut,
  input wire logic       resetPinOe,
  input wire logic       lowVoltageLampOut,
  input wire logic       lowVoltageLampOe,
  input wire logic       hvLampDriverOne,
  input wire logic       hvLampDriverTwo,
  input wire logic       driversInhibit,
  input wire regReq_s    regReq,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic        wdEn_q;
  logic        en1_q;
  logic [15:0] oeRun_q;
  logic [15:0] otRun_q;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control bits, so lamp and fault gating can be judged
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wdEn_q <= 1'b0;
      en1_q  <= 1'b0;
    end else if (regReq.wr && regReq.addr == ADDR_CTRL) begin
      wdEn_q <= regReq.wdata[CTL_WDEN_BIT];
      en1_q  <= regReq.wdata[CTL_EN1_BIT];
    end
  end

  // run lengths of the reset drive and the raw overtemp level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      oeRun_q <= 16'h0000;
      otRun_q <= 16'h0000;
    end else begin
      oeRun_q <= resetPinOe ? oeRun_q + 16'h0001 : 16'h0000;
      otRun_q <= faultPins.overTemp ? otRun_q + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_lamp_gate_one: assert property (!lampGateInputOne [*5] |-> !hvLampDriverOne)
    else $error("lamp one on without its gate");
  a_lamp_en_one: assert property (!en1_q [*3] |-> !hvLampDriverOne)
    else $error("lamp one on without its enable");
  a_uv_lamps_off: assert property (faultPins.underVolt [*5] |->
    !hvLampDriverOne && !hvLampDriverTwo) else $error("lamp on in undervoltage");
  a_ot_lamps_off: assert property (otRun_q > 16'(OT_DEGLITCH_CYC + 4) |->
    !hvLampDriverOne && !hvLampDriverTwo) else $error("lamp on in overtemp");
  a_inhibit_lamps: assert property (driversInhibit |->
    !hvLampDriverOne && !hvLampDriverTwo && lowVoltageLampOe)
    else $error("watchdog fault outputs inconsistent");
  a_wd_off_quiet: assert property (!wdEn_q [*4] |-> !driversInhibit)
    else $error("inhibit while watchdog disabled");
  a_fault_on_enable: assert property ($rose(wdEn_q) |->
    ##[1:4] (lowVoltageLampOe && driversInhibit)) else $error("no fault at zero count");
  a_por_hold: assert property ($rose(rstn) |-> resetPinOe [*8])
    else $error("reset pin not held after power-on");
  a_rst_pulse_len: assert property ($fell(resetPinOe) |->
    oeRun_q >= 16'(RST_PULSE_CYC)) else $error("reset pulse too short");
  a_rd_unmapped: assert property (regReq.rd && regReq.addr == 6'h3F |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  c_fault: cover property ($rose(lowVoltageLampOe));
  c_wd_reset: cover property ($fell(resetPinOe) && wdEn_q);
  c_lamp_on: cover property ($rose(hvLampDriverOne));
endmodule

bind wdog_lamp_reset_supervisor wdog_lamp_props wdog_lamp_props_i (
  .mclk(mclk), .rstn(rstn), .watchdogPulseIn(watchdogPulseIn),
  .lampGateInputOne(lampGateInputOne), .lampGateInputTwo(lampGateInputTwo),
  .faultPins(faultPins), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
  .resetPinOe(resetPinOe), .lowVoltageLampOut(lowVoltageLampOut),
  .lowVoltageLampOe(lowVoltageLampOe), .hvLampDriverOne(hvLampDriverOne),
  .hvLampDriverTwo(hvLampDriverTwo), .driversInhibit(driversInhibit),
  .regReq(regReq), .regRdData(regRdData));

//--- verif/mcu_model.sv
// behavioural controller: sends watchdog pulses and can pull the reset pad low
// assumes the bench resolves the open-drain pad from both enables
module mcu_model (
  input  wire logic mclk,
  output logic      wdPin,
  output logic      rstPullOe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wdPin     = 1'b0;
    rstPullOe = 1'b0;
  end

  // low gap after each pulse leaves room for the counter to settle
  task automatic pulse(input int hiCyc);
    @(negedge mclk);
    wdPin = 1'b1;
    repeat (hiCyc) @(negedge mclk);
    wdPin = 1'b0;
    repeat (200) @(negedge mclk);
  endtask

  task automatic ext_reset(input int n);
    @(negedge mclk);
    rstPullOe = 1'b1;
    repeat (n) @(negedge mclk);
    rstPullOe = 1'b0;
  endtask
endmodule

//--- verif/tb_wdog_lamp_reset_supervisor.sv
// self-checking bench for the watchdog / lamp supervisor
// assumes the controller model on the pulse pin; reads are scored from a queue
module tb_wdog_lamp_reset_supervisor import wdog_lamp_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk;
  logic       rstn;
  logic       gate1;
  logic       gate2;
  faultPins_s fp;
  regReq_s    req;
  logic       wdPin;
  logic       pullOe;
  logic       pad;
  logic       rstOe;
  logic       rstOut;
  logic       lvOut;
  logic       lvOe;
  logic       hv1;
  logic       hv2;
  logic       inhib;
  logic [7:0] rdData;
  logic       rdLag;
  int         n_mismatch;
  int         num_checks;
  int         cyc;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];

  // open-drain pad with pull-up: low if either side pulls it
  assign pad = (rstOe ? rstOut : 1'b1) & ~pullOe;
  wdog_lamp_reset_supervisor #(.REARM_CYC(50)) wdog_lamp_reset_supervisor_i (
    .mclk(mclk), .rstn(rstn), .watchdogPulseIn(wdPin), .lampGateInputOne(gate1),
    .lampGateInputTwo(gate2), .faultPins(fp), .resetPinIn(pad), .resetPinOut(rstOut),
    .resetPinOe(rstOe), .lowVoltageLampOut(lvOut), .lowVoltageLampOe(lvOe),
    .hvLampDriverOne(hv1), .hvLampDriverTwo(hv2), .driversInhibit(inhib),
    .regReq(req), .regRdData(rdData));
  mcu_model mcu_model_i (.mclk(mclk), .wdPin(wdPin), .rstPullOe(pullOe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fail(input string what, input logic [7:0] e, input logic [7:0] s);
    n_mismatch++;
    $display("[ERR] %s expected %h seen %h", what, e, s);
  endtask

  task automatic chk(input string what, input logic v, input logic e);
    num_checks++;
    if (v !== e) fail(what, {7'h00, e}, {7'h00, v});
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    expQ.push_back(e);
    mskQ.push_back(m);
    @(negedge mclk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.rd = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  // read data stands from the edge that takes the strobe, so compare mid-cycle
  always @(posedge mclk) rdLag <= req.rd;
  always @(negedge mclk) begin
    if (rdLag === 1'b1) begin
      num_checks++;
      if ((rdData & mskQ[0]) !== expQ[0]) fail("read data", expQ[0], rdData & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    rstn = 1'b0;
    gate1 = 1'b0;
    gate2 = 1'b0;
    fp = '0;
    req = '0;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(32'h40AC));
    w(20);
    rstn = 1'b1;
    w(2);
    chk("reset pin", rstOe, 1'b1);
    rd(ADDR_CTRL, 8'hFF, CTRL_RST);
    rd(6'h3F, 8'hFF, 8'h00);
    w(520);
    chk("reset pin", rstOe, 1'b0);
    rd(ADDR_GLOBAL, 8'h09, 8'h00);
    rd(ADDR_LAMP, 8'h4F, 8'h00);
    wr(ADDR_CTRL, 8'h03);
    gate1 = 1'b1;
    w(6);
    chk("lamp one", hv1, 1'b1);
    chk("lamp two", hv2, 1'b0);
    gate2 = 1'b1;
    w(6);
    chk("lamp two", hv2, 1'b1);
    gate2 = 1'b0;
    fp.overCur = 2'b01;
    w(OC_DEGLITCH_CYC + 10);
    chk("lamp one", hv1, 1'b1);
    fp.overCur = 2'b00;
    // the live fault needs a few cycles to leave the synchroniser and filter
    w(4);
    rd(ADDR_LAMP, 8'h01, 8'h01);
    rd(ADDR_LAMP, 8'h01, 8'h00);
    rd(ADDR_GLOBAL, 8'h01, 8'h01);
    rd(ADDR_GLOBAL, 8'h01, 8'h00);
    fp.openLoad = 2'b10;
    w(6);
    fp.openLoad = 2'b00;
    rd(ADDR_LAMP, 8'h08, 8'h08);
    rd(ADDR_GLOBAL, 8'h01, 8'h01);
    fp.overTemp = 1'b1;
    w(OT_DEGLITCH_CYC + 10);
    chk("lamp one", hv1, 1'b0);
    fp.overTemp = 1'b0;
    w(6);
    chk("lamp one", hv1, 1'b1);
    rd(ADDR_LAMP, 8'h40, 8'h40);
    rd(ADDR_LAMP, 8'h4F, 8'h00);
    fp.underVolt = 1'b1;
    w(6);
    chk("lamp one", hv1, 1'b0);
    rd(ADDR_GLOBAL, 8'h11, 8'h10);
    fp.underVolt = 1'b0;
    w(6);
    wr(ADDR_CTRL, 8'h13);
    w(6);
    chk("low lamp", lvOe, 1'b1);
    chk("low lamp level", lvOut, 1'b0);
    chk("inhibit", inhib, 1'b1);
    chk("lamp one", hv1, 1'b0);
    rd(ADDR_GLOBAL, 8'h01, 8'h00);
    rd(ADDR_CTRL, 8'h80, 8'h80);
    for (k = 0; k < 8; k++) begin
      mcu_model_i.pulse((101 + int'($urandom % 20)) * WD_TICK_CYC);
      rd(ADDR_WDCNT, 8'h07, (k < 6) ? 8'(k + 1) : 8'h07);
    end
    rd(ADDR_WDCNT, 8'h0F, 8'h0F);
    w(4);
    chk("low lamp", lvOe, 1'b0);
    chk("lamp one", hv1, 1'b1);
    // a width inside the default window falls short of the raised lower limit
    wr(ADDR_WCFG, 8'h10);
    mcu_model_i.pulse(110 * WD_TICK_CYC);
    rd(ADDR_WDCNT, 8'h07, 8'h04);
    wr(ADDR_WCFG, WCFG_RST);
    mcu_model_i.pulse(20 * WD_TICK_CYC);
    rd(ADDR_WDCNT, 8'h07, 8'h01);
    mcu_model_i.pulse(20 * WD_TICK_CYC);
    chk("reset pin", rstOe, 1'b1);
    rd(ADDR_CTRL, 8'h80, 8'h80);
    rd(ADDR_WDCNT, 8'h0F, 8'h00);
    w(600);
    mcu_model_i.pulse(110 * WD_TICK_CYC);
    rd(ADDR_WDCNT, 8'h07, 8'h01);
    rd(ADDR_GLOBAL, 8'h08, 8'h00);
    mcu_model_i.ext_reset(10);
    w(10);
    rd(ADDR_GLOBAL, 8'h08, 8'h08);
    rd(ADDR_GLOBAL, 8'h08, 8'h00);
    // silent pin: twice the 1000 us upper window is 50000 cycles from the last edge
    k = 0;
    while (!rstOe && k < 52000) begin
      w(1);
      k++;
    end
    chk("silence length", (k > 49000), 1'b1);
    chk("reset pin", rstOe, 1'b1);
    rd(ADDR_CTRL, 8'h80, 8'h80);
    rd(ADDR_WDCNT, 8'h0F, 8'h00);
    w(4);
    print_verdict();
  end
endmodule
